// file: duhp_pkg.sv
/*
  duhp_pkg: shared constants of the dual serial controller host port.
  Holds register-select offsets, command codes, field positions and reset values.
  Assumes every user imports the whole package.
*/
package duhp_pkg;

  // register-select offsets, channel a at 0x0 to 0x2 and channel b at 0x8 to 0xA, the others shared
  localparam logic [3:0] DUHP_OFF_MODE_A   = 4'h0;
  localparam logic [3:0] DUHP_OFF_STATUS_A = 4'h1;
  localparam logic [3:0] DUHP_OFF_CMD_A    = 4'h2;
  localparam logic [3:0] DUHP_OFF_IRQ      = 4'h5;  // read irq status, write irq mask
  localparam logic [3:0] DUHP_OFF_CT_HI    = 4'h6;
  localparam logic [3:0] DUHP_OFF_CT_LO    = 4'h7;
  localparam logic [3:0] DUHP_OFF_MODE_B   = 4'h8;
  localparam logic [3:0] DUHP_OFF_STATUS_B = 4'h9;
  localparam logic [3:0] DUHP_OFF_CMD_B    = 4'hA;
  localparam logic [3:0] DUHP_OFF_OUTPUT_PORT_CONFIG_REG     = 4'hD;
  localparam logic [3:0] DUHP_OFF_OP_SET   = 4'hE;  // write sets output bits, driving pins low; read starts timer
  localparam logic [3:0] DUHP_OFF_OP_CLR   = 4'hF;  // write clears output bits, driving pins high; read stops timer

  // command register fields
  localparam int         DUHP_CMD_TX_EN_BIT  = 2;
  localparam int         DUHP_CMD_TX_DIS_BIT = 3;
  localparam int         DUHP_CMD_CODE_LSB   = 4;
  localparam logic [2:0] DUHP_CODE_PTR_RST   = 3'h1;
  localparam logic [2:0] DUHP_CODE_STAT_CLR  = 3'h4;
  localparam logic [2:0] DUHP_CODE_TEST_SET  = 3'h7;

  // reset values
  localparam logic [7:0]  DUHP_RST_BYTE   = 8'h00;
  localparam logic [15:0] DUHP_RST_CT     = 16'h0000;
  localparam logic        DUHP_LINE_MARK  = 1'b1;

endpackage : duhp_pkg

// file: duhp_host_port.sv
/*
  duhp_host_port: host-side parallel port of a dual asynchronous serial controller,
  with the reset behaviour and the shared interrupt request.
  Assumes all host pins are synchronous to clk_in; the data bus and the interrupt
  line are resolved outside from the output enables.
*/
// How it works
// - bus transfers happen only while chip select is low, steered by strobes and select
// - chip select high keeps all eight data lines undriven
// - write data is taken into the addressed register on the write strobe rise
// - read strobe low with chip select low drives the addressed register out
// - data bit zero carries the least significant bit of every byte
// - reset clears both status, irq mask, irq status, output value and output config
// - reset drives all eight general output pins high
// - reset stops the counter until software starts it again
// - reset idles both channels with both serial outputs at mark
// - reset clears test mode and points each mode access at the first mode register
// - irq line pulled low while any of eight masked conditions holds
`timescale 1ns/1ps
module duhp_host_port
  import duhp_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int SEL_W  = 4
) (
  // clock and resets
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              reset_pin_in,
  // host bus
  input  wire logic              chip_select_low_in,
  input  wire logic              read_strobe_low_in,
  input  wire logic              write_strobe_low_in,
  input  wire logic [SEL_W-1:0]  register_select_in,
  input  wire logic [DATA_W-1:0] host_data_bus_in,
  output logic      [DATA_W-1:0] host_data_bus_out,
  output logic                   host_data_bus_oe_out,
  // channel side
  input  wire logic [7:0]        status_event_a_in,
  input  wire logic [7:0]        status_event_b_in,
  input  wire logic [7:0]        irq_condition_in,
  input  wire logic              tx_bit_a_in,
  input  wire logic              tx_bit_b_in,
  output logic                   serial_out_a_out,
  output logic                   serial_out_b_out,
  // ports, timer, interrupt
  output logic [7:0]             general_output_pins_out,
  output logic [7:0]             output_port_config_out,
  output logic                   timer_running_out,
  output logic                   test_mode_out,
  output logic                   irq_request_low_out,
  output logic                   irq_request_oe_out
);

  // the byte lane is fixed by the pin count, the select field by the map
  if (DATA_W != 8) begin : g_bad_width
    $error("duhp_host_port: DATA_W must be 8");
  end
  if (SEL_W != 4) begin : g_bad_sel
    $error("duhp_host_port: SEL_W must be 4");
  end

  logic [7:0]       wdata_q;
  logic [SEL_W-1:0] waddr_q;
  logic             wr_was_q;
  logic             rd_was_q;
  logic             wr_active;
  logic             rd_active;
  logic             wr_commit;
  logic             rd_start;
  logic [1:0][7:0]  mode1_q;
  logic [1:0][7:0]  mode2_q;
  logic [1:0][7:0]  status_q;
  logic [1:0]       ptr_q;
  logic [1:0]       tx_en_q;
  logic [7:0]       irq_mask_q;
  logic [7:0]       irq_status_q;
  logic [7:0]       opr_q;
  logic [7:0]       output_port_config_reg_q;
  logic [15:0]      ct_preset_q;
  logic [15:0]      ct_count_q;
  logic             ct_running_q;
  logic             test_mode_q;
  logic [7:0]       rd_mux;
  logic [7:0]       rdata_q;
  logic             wch;
  logic             rch;
  logic [2:0]       wcode;

  // both strobes low together is a host fault: neither a read nor a write
  assign wr_active = !chip_select_low_in && !write_strobe_low_in
                     && read_strobe_low_in;
  assign rd_active = !chip_select_low_in && !read_strobe_low_in
                     && write_strobe_low_in;
  assign wr_commit = wr_was_q && !wr_active && write_strobe_low_in;
  assign rd_start  = rd_active && !rd_was_q;
  assign wch       = waddr_q[3];
  assign rch       = register_select_in[3];
  assign wcode     = wdata_q[DUHP_CMD_CODE_LSB +: 3];

  // strobe history; data and select are held from the last cycle of the low phase
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_was_q <= 1'b0;
      rd_was_q <= 1'b0;
      wdata_q  <= DUHP_RST_BYTE;
      waddr_q  <= '0;
    end else begin
      wr_was_q <= wr_active;
      rd_was_q <= rd_active;
      if (wr_active) begin
        wdata_q <= host_data_bus_in;
        waddr_q <= register_select_in;
      end
    end
  end

  // per-channel mode registers, pointer, status and transmitter enable
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode1_q  <= '0;
      mode2_q  <= '0;
      status_q <= '0;
      ptr_q    <= '0;
      tx_en_q  <= '0;
    end else if (reset_pin_in) begin
      status_q <= '0;
      ptr_q    <= '0;
      tx_en_q  <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        // set wins over the clear command in the same cycle
        status_q[c] <= (c == 0) ? status_event_a_in : status_event_b_in;
        if (!(wr_commit && waddr_q[2:0] == DUHP_OFF_CMD_A[2:0] && wch == c[0]
              && wcode == DUHP_CODE_STAT_CLR)) begin
          status_q[c] <= status_q[c]
                         | ((c == 0) ? status_event_a_in : status_event_b_in);
        end
      end
      if (wr_commit && waddr_q[2:0] == DUHP_OFF_MODE_A[2:0]) begin
        if (!ptr_q[wch]) begin
          mode1_q[wch] <= wdata_q;
        end else begin
          mode2_q[wch] <= wdata_q;
        end
        ptr_q[wch] <= 1'b1;
      end else if (rd_start && register_select_in[2:0] == DUHP_OFF_MODE_A[2:0]) begin
        ptr_q[rch] <= 1'b1;                                        // a read also advances
      end
      if (wr_commit && waddr_q[2:0] == DUHP_OFF_CMD_A[2:0]) begin
        if (wcode == DUHP_CODE_PTR_RST) begin
          ptr_q[wch] <= 1'b0;
        end
        if (wdata_q[DUHP_CMD_TX_DIS_BIT]) begin
          tx_en_q[wch] <= 1'b0;                                    // disable beats enable
        end else if (wdata_q[DUHP_CMD_TX_EN_BIT]) begin
          tx_en_q[wch] <= 1'b1;
        end
      end
    end
  end

  // test mode entered by command, left only by reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      test_mode_q <= 1'b0;
    end else if (reset_pin_in) begin
      test_mode_q <= 1'b0;
    end else if (wr_commit && waddr_q[2:0] == DUHP_OFF_CMD_A[2:0]
                 && wcode == DUHP_CODE_TEST_SET) begin
      test_mode_q <= 1'b1;
    end
  end

  // interrupt mask and status, output port value and configuration
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask_q   <= DUHP_RST_BYTE;
      irq_status_q <= DUHP_RST_BYTE;
      opr_q        <= DUHP_RST_BYTE;
      output_port_config_reg_q       <= DUHP_RST_BYTE;
    end else if (reset_pin_in) begin
      irq_mask_q   <= DUHP_RST_BYTE;
      irq_status_q <= DUHP_RST_BYTE;
      opr_q        <= DUHP_RST_BYTE;
      output_port_config_reg_q       <= DUHP_RST_BYTE;
    end else begin
      irq_status_q <= irq_condition_in;                            // follows live conditions
      if (wr_commit) begin
        case (waddr_q)
          DUHP_OFF_IRQ:    irq_mask_q <= wdata_q;
          DUHP_OFF_OUTPUT_PORT_CONFIG_REG:   output_port_config_reg_q     <= wdata_q;
          DUHP_OFF_OP_SET: opr_q      <= opr_q | wdata_q;          // bitwise set
          DUHP_OFF_OP_CLR: opr_q      <= opr_q & ~wdata_q;         // bitwise clear
          default:         opr_q      <= opr_q;
        endcase
      end
    end
  end

  // counter/timer: preset by writes, started and stopped by reads
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ct_preset_q  <= DUHP_RST_CT;
      ct_count_q   <= DUHP_RST_CT;
      ct_running_q <= 1'b0;
    end else if (reset_pin_in) begin
      ct_running_q <= 1'b0;
    end else begin
      if (wr_commit && waddr_q == DUHP_OFF_CT_HI) begin
        ct_preset_q[15:8] <= wdata_q;
      end
      if (wr_commit && waddr_q == DUHP_OFF_CT_LO) begin
        ct_preset_q[7:0] <= wdata_q;
      end
      if (rd_start && register_select_in == DUHP_OFF_OP_SET) begin
        ct_running_q <= 1'b1;
        ct_count_q   <= ct_preset_q;
      end else if (rd_start && register_select_in == DUHP_OFF_OP_CLR) begin
        ct_running_q <= 1'b0;
      end else if (ct_running_q) begin
        // reload on zero so the period is preset plus one cycle
        ct_count_q <= (ct_count_q == DUHP_RST_CT) ? ct_preset_q : ct_count_q - 16'h0001;
      end
    end
  end

  // read selection on the live select lines
  always_comb begin
    rd_mux = DUHP_RST_BYTE;
    case (register_select_in)
      DUHP_OFF_MODE_A:   rd_mux = ptr_q[0] ? mode2_q[0] : mode1_q[0];
      DUHP_OFF_MODE_B:   rd_mux = ptr_q[1] ? mode2_q[1] : mode1_q[1];
      DUHP_OFF_STATUS_A: rd_mux = status_q[0];
      DUHP_OFF_STATUS_B: rd_mux = status_q[1];
      DUHP_OFF_IRQ:      rd_mux = irq_status_q;
      DUHP_OFF_CT_HI:    rd_mux = ct_count_q[15:8];
      DUHP_OFF_CT_LO:    rd_mux = ct_count_q[7:0];
      default:           rd_mux = DUHP_RST_BYTE;                   // unmapped reads zero
    endcase
  end

  // read data registered; valid one cycle after the strobe falls
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= DUHP_RST_BYTE;
    end else if (rd_active) begin
      rdata_q <= rd_mux;
    end
  end

  // bus drive only during a read; enable is combinational for fast turn-off
  assign host_data_bus_oe_out    = rd_active;
  assign host_data_bus_out       = rdata_q;
  assign general_output_pins_out = ~opr_q;                         // pins show complement
  assign output_port_config_out  = output_port_config_reg_q;
  assign timer_running_out       = ct_running_q;
  assign test_mode_out           = test_mode_q;
  assign serial_out_a_out        = tx_en_q[0] ? tx_bit_a_in : DUHP_LINE_MARK;
  assign serial_out_b_out        = tx_en_q[1] ? tx_bit_b_in : DUHP_LINE_MARK;
  assign irq_request_oe_out      = |(irq_status_q & irq_mask_q);
  assign irq_request_low_out     = 1'b0;                           // open drain only pulls low

  // checks
  sequence s_write_rise;
    wr_active ##1 (!wr_active && write_strobe_low_in);
  endsequence

  a_bus_tristate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    chip_select_low_in |-> !host_data_bus_oe_out)
    else $error("data bus driven while deselected");
  a_read_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rd_active && register_select_in == DUHP_OFF_STATUS_A && !reset_pin_in)
      ##1 rd_active |-> host_data_bus_oe_out && host_data_bus_out == $past(status_q[0]))
    else $error("read does not show addressed register");
  a_lsb_order: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rd_active && register_select_in == DUHP_OFF_IRQ)
      |=> host_data_bus_out[0] == $past(irq_status_q[0]))
    else $error("bit zero not the low bit");
  a_write_commit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write_rise ##0 (waddr_q == DUHP_OFF_IRQ && !reset_pin_in)
      |=> irq_mask_q == $past(wdata_q, 1))
    else $error("mask write not taken on strobe rise");
  a_reset_regs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reset_pin_in |=> (status_q == '0 && irq_mask_q == 8'h00 && opr_q == 8'h00
                      && output_port_config_reg_q == 8'h00 && irq_status_q == 8'h00))
    else $error("reset left a register set");
  a_reset_pins: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reset_pin_in [*2] |-> general_output_pins_out == 8'hFF)
    else $error("output pins not high in reset");
  a_reset_timer: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reset_pin_in ##1 !reset_pin_in[*2] ##0 !rd_was_q[*2] |-> !timer_running_out)
    else $error("timer runs after reset without start");
  a_reset_mark: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reset_pin_in |=> (serial_out_a_out && serial_out_b_out))
    else $error("serial output not at mark after reset");
  a_reset_test: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reset_pin_in |=> (!test_mode_out && ptr_q == 2'b00))
    else $error("test mode or mode pointer not reset");
  a_irq_level: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !reset_pin_in ##1 (irq_condition_in & irq_mask_q) != 8'h00 ##0 !reset_pin_in
      |=> ($past(irq_mask_q) != irq_mask_q || irq_request_oe_out))
    else $error("irq not asserted for masked condition");

endmodule : duhp_host_port

// file: duhp_host_model.sv
/*
  duhp_host_model: behavioural host processor on the 8-bit strobe bus.
  Assumes the bench resolves the shared data bus from both output enables.
*/
`timescale 1ns/1ps
module duhp_host_model
  import duhp_pkg::*;
(
  // clock
  input  wire logic       clk_in,
  // bus pins towards the port
  output logic            chip_select_low_out,
  output logic            read_strobe_low_out,
  output logic            write_strobe_low_out,
  output logic [3:0]      register_select_out,
  output logic [7:0]      data_out,
  output logic            data_oe_out,
  // resolved bus and the port's enable
  input  wire logic [7:0] bus_in,
  input  wire logic       dev_oe_in
);
  // idle bus: nothing selected, nothing driven
  initial begin
    chip_select_low_out  = 1'b1;
    read_strobe_low_out  = 1'b1;
    write_strobe_low_out = 1'b1;
    register_select_out  = 4'h0;
    data_out             = 8'h00;
    data_oe_out          = 1'b0;
  end

  // write: select and data held through the strobe rise, one idle cycle after
  task automatic write_reg(input logic [3:0] sel, input logic [7:0] val, input logic use_cs);
    @(negedge clk_in);
    chip_select_low_out  = !use_cs;
    register_select_out  = sel;
    data_out             = val;
    data_oe_out          = 1'b1;
    write_strobe_low_out = 1'b0;
    @(negedge clk_in);
    write_strobe_low_out = 1'b1;
    @(negedge clk_in);
    chip_select_low_out  = 1'b1;
    data_oe_out          = 1'b0;
    @(negedge clk_in);
  endtask : write_reg

  // read: data taken one edge after the strobe is first sampled
  task automatic read_reg(input logic [3:0] sel, output logic [7:0] val,
                          output logic oe_seen, input logic use_cs);
    @(negedge clk_in);
    chip_select_low_out = !use_cs;
    register_select_out = sel;
    read_strobe_low_out = 1'b0;
    @(negedge clk_in);
    val     = bus_in;
    oe_seen = dev_oe_in;
    @(negedge clk_in);
    chip_select_low_out = 1'b1;
    read_strobe_low_out = 1'b1;
  endtask : read_reg
endmodule : duhp_host_model

// file: dual_uart_host_bus_port_tb.sv
/*
  dual_uart_host_bus_port_tb: self-checking bench of the host port.
  Assumes the host model drives the bus pins; other inputs change at falling edges.
*/
`timescale 1ns/1ps
module dual_uart_host_bus_port_tb;
  import duhp_pkg::*;
  logic       clk_in, reset_n_in, reset_pin_in, cs_l, rd_l, wr_l, host_oe, dev_oe;
  logic       tx_a, tx_b, irq_low, irq_oe, ser_a, ser_b, t_run, t_mode, oe_v;
  logic       idle_pat = 1'b0;
  logic [3:0] sel;
  logic [7:0] host_d, dev_d, bus, ev_a, ev_b, cond, pins, cfg, rd_v, output_port_value_reg, m, s, k, e;
  int         bad_count, check_count, seed, i;

  // no pull on the data bus, so an idle bus shows a changing pattern
  assign bus = dev_oe ? dev_d : (host_oe ? host_d : ({8{idle_pat}} ^ 8'hA5));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) idle_pat <= ~idle_pat;

  duhp_host_port u_duhp_host_port (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reset_pin_in(reset_pin_in), .chip_select_low_in(cs_l), .read_strobe_low_in(rd_l),
    .write_strobe_low_in(wr_l), .register_select_in(sel), .host_data_bus_in(bus),
    .host_data_bus_out(dev_d), .host_data_bus_oe_out(dev_oe), .status_event_a_in(ev_a),
    .status_event_b_in(ev_b), .irq_condition_in(cond), .tx_bit_a_in(tx_a),
    .tx_bit_b_in(tx_b), .serial_out_a_out(ser_a), .serial_out_b_out(ser_b),
    .general_output_pins_out(pins), .output_port_config_out(cfg), .timer_running_out(t_run),
    .test_mode_out(t_mode), .irq_request_low_out(irq_low), .irq_request_oe_out(irq_oe));

  duhp_host_model u_host (.clk_in(clk_in), .chip_select_low_out(cs_l),
    .read_strobe_low_out(rd_l), .write_strobe_low_out(wr_l), .register_select_out(sel),
    .data_out(host_d), .data_oe_out(host_oe), .bus_in(bus), .dev_oe_in(dev_oe));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // interrupt line expected from mask and live conditions
  function automatic logic [7:0] exp_irq(input logic [7:0] mask, input logic [7:0] conds);
    return {7'h00, |(mask & conds)};
  endfunction : exp_irq

  // safe state that either reset must leave behind
  task automatic check_reset_state();
    check("pins", pins, 8'hFF);
    check("config", cfg, 8'h00);
    check("ser_a", {7'h00, ser_a}, 8'h01);
    check("ser_b", {7'h00, ser_b}, 8'h01);
    check("timer", {7'h00, t_run}, 8'h00);
    check("test_mode", {7'h00, t_mode}, 8'h00);
    check("irq_oe", {7'h00, irq_oe}, 8'h00);
  endtask : check_reset_state

  initial begin
    seed = 28;
    bad_count = 0;
    check_count = 0;
    reset_n_in = 1'b0;
    reset_pin_in = 1'b0;
    {ev_a, ev_b, cond, output_port_value_reg} = 32'h0000_0000;
    {tx_a, tx_b} = 2'b00;
    repeat (12) @(negedge clk_in);
    reset_n_in = 1'b1;
    check_reset_state();
    // load everything the reset pin must clear, and both mode registers
    u_host.write_reg(DUHP_OFF_MODE_A, 8'h11, 1'b1);
    u_host.write_reg(DUHP_OFF_MODE_A, 8'h22, 1'b1);
    m = 8'($random(seed));
    u_host.write_reg(DUHP_OFF_OUTPUT_PORT_CONFIG_REG, m, 1'b1);
    check("config", cfg, m);
    u_host.write_reg(DUHP_OFF_IRQ, 8'hFF, 1'b1);
    u_host.write_reg(DUHP_OFF_OP_SET, 8'h3C, 1'b1);
    check("pins", pins, 8'hC3);
    u_host.read_reg(DUHP_OFF_OP_SET, rd_v, oe_v, 1'b1);
    check("timer", {7'h00, t_run}, 8'h01);
    u_host.write_reg(DUHP_OFF_CMD_A, 8'h74, 1'b1);
    u_host.write_reg(DUHP_OFF_CMD_B, 8'h04, 1'b1);
    check("test_mode", {7'h00, t_mode}, 8'h01);
    check("ser_a", {7'h00, ser_a}, 8'h00);
    check("ser_b", {7'h00, ser_b}, 8'h00);
    ev_a = 8'h81;
    ev_b = 8'h18;
    cond = 8'h01;
    @(negedge clk_in);
    {ev_a, ev_b} = 16'h0000;
    @(negedge clk_in);
    check("irq_oe", {7'h00, irq_oe}, 8'h01);
    // reset pin held for a few cycles, state checked while it is high
    reset_pin_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check_reset_state();
    reset_pin_in = 1'b0;
    // quiet gap so the timer must stay stopped with no start read
    repeat (2) @(negedge clk_in);
    check("timer_held", {7'h00, t_run}, 8'h00);
    u_host.read_reg(DUHP_OFF_STATUS_A, rd_v, oe_v, 1'b1);
    check("status_a", rd_v, 8'h00);
    u_host.read_reg(DUHP_OFF_STATUS_B, rd_v, oe_v, 1'b1);
    check("status_b", rd_v, 8'h00);
    u_host.read_reg(DUHP_OFF_MODE_A, rd_v, oe_v, 1'b1);
    check("mode_first", rd_v, 8'h11);
    cond = 8'hFF;
    repeat (2) @(negedge clk_in);
    check("irq_masked", {7'h00, irq_oe}, 8'h00);
    // random traffic: interrupts, output bits, refused cycles, sticky status
    for (i = 0; i < 12; i++) begin
      {m, s, k, e} = $random(seed);
      u_host.write_reg(DUHP_OFF_IRQ, m, 1'b1);
      cond = 8'($random(seed));
      tx_a = i[1];
      repeat (2) @(negedge clk_in);
      check("irq_oe", {7'h00, irq_oe}, exp_irq(m, cond));
      check("irq_level", {7'h00, irq_low}, 8'h00);
      u_host.read_reg(DUHP_OFF_IRQ, rd_v, oe_v, 1'b1);
      check("irq_status", rd_v, cond);
      check("read_oe", {7'h00, oe_v}, 8'h01);
      u_host.write_reg(DUHP_OFF_OP_SET, s, 1'b1);
      u_host.write_reg(DUHP_OFF_OP_CLR, k, 1'b1);
      output_port_value_reg = (output_port_value_reg | s) & ~k;
      check("pins", pins, ~output_port_value_reg);
      u_host.write_reg(DUHP_OFF_OUTPUT_PORT_CONFIG_REG, e | 8'h01, 1'b0);
      check("config_no_cs", cfg, 8'h00);
      u_host.read_reg(DUHP_OFF_OP_SET, rd_v, oe_v, 1'b0);
      check("oe_no_cs", {7'h00, oe_v}, 8'h00);
      check("timer_no_cs", {7'h00, t_run}, 8'h00);
      check("ser_a_idle", {7'h00, ser_a}, 8'h01);
      @(negedge clk_in);
      if (i[0]) ev_b = e; else ev_a = e;
      @(negedge clk_in);
      {ev_a, ev_b} = 16'h0000;
      u_host.read_reg(i[0] ? DUHP_OFF_STATUS_B : DUHP_OFF_STATUS_A, rd_v, oe_v, 1'b1);
      check("status", rd_v, e);
      u_host.write_reg(i[0] ? DUHP_OFF_CMD_B : DUHP_OFF_CMD_A,
                       {1'b0, DUHP_CODE_STAT_CLR, 4'h0}, 1'b1);
      u_host.read_reg(i[0] ? DUHP_OFF_STATUS_B : DUHP_OFF_STATUS_A, rd_v, oe_v, 1'b1);
      check("status_clr", rd_v, 8'h00);
    end
    report_and_stop();
  end
endmodule : dual_uart_host_bus_port_tb
